/* File: rtl/febs_ctrl.sv */
// Host controller issuing erase, blank check, suspend and resume to a flash
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps

module febs_ctrl
  import febs_pkg::*;
#(
  parameter int ADDR_W = 24  // Flash address width
) (
  input  wire logic             clk,          // 250 MHz clock
  input  wire logic             rst,          // Synchronous reset
  input  wire logic [3:0]       regAddr,      // Register address
  input  wire logic [15:0]      regWdata,     // Register write data
  input  wire logic             regWr,        // Write strobe
  input  wire logic             regRd,        // Read strobe
  output logic      [15:0]      regRdata,     // Read data, one cycle later
  output febs_pkg::febs_pins_t  pins,         // Flash control pins
  input  wire logic [15:0]      flashDataIn,  // Flash data bus input
  input  wire logic             readyBusyIn   // Ready/busy pin level
);
  import febs_pkg::*;

  // ----------------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------------
  typedef enum {S_IDLE, S_WR1, S_GAP, S_WR2, S_RD, S_DONE} febs_state_t;

  febs_state_t  state, next_state;                  // Bus sequencer state
  logic [7:0]   cnt, next_cnt;                      // Strobe timer
  logic [2:0]   op, next_op;                        // Operation in flight
  logic [15:0]  blockAddr, next_blockAddr;          // Latched block address
  logic [7:0]   flashStat, next_flashStat;          // Last status byte
  logic [15:0]  arrayWord, next_arrayWord;          // Last array word
  logic         refused, next_refused;              // Last command refused
  logic         inStatusMode, next_inStatusMode;    // Flash read mode
  logic         errLatch, next_errLatch;            // Error not yet cleared
  febs_pins_t   next_pins;                          // Next pin values
  logic [15:0]  next_regRdata;                      // Next read data
  logic [SYNC_STAGES-1:0] rbSync;                   // Ready pin synchroniser
  logic [15:0]  dataMeta, dataSync;                 // Flash data bus synchroniser
  logic         rbLevel;                            // Synchronised ready

  // ----------------------------------------------------------------------
  // Ready/busy synchroniser
  // ----------------------------------------------------------------------
  // Both pin inputs pass two flops; read data is held long enough to settle
  always_ff @(posedge clk) begin
    if (rst) begin
      rbSync   <= '1;  // Idle level of the ready pin
      dataMeta <= 16'h0000;
      dataSync <= 16'h0000;
    end else begin
      rbSync   <= {rbSync[SYNC_STAGES-2:0], readyBusyIn};
      dataMeta <= flashDataIn;
      dataSync <= dataMeta;
    end
  end
  assign rbLevel = rbSync[SYNC_STAGES-1];

  // Decode of the two data words for an operation
  function automatic logic [31:0] op_words(input logic [2:0] o);
    case (o)
      OP_ERASE:  op_words = {CMD_ERASE_SETUP, CMD_CONFIRM};
      OP_BLANK:  op_words = {CMD_BLANK_SETUP, CMD_BLANK_CONF};
      OP_SUSP:   op_words = {CMD_SUSPEND, 16'h0000};
      OP_RESUME: op_words = {CMD_CONFIRM, 16'h0000};
      OP_CLEAR:  op_words = {CMD_CLEAR_STATUS, 16'h0000};
      OP_POLL:   op_words = {CMD_READ_STATUS, 16'h0000};
      OP_READ:   op_words = {CMD_READ_ARRAY, 16'h0000};
      default:   op_words = 32'h0000_0000;
    endcase
  endfunction

  // Whether an operation needs a second write cycle
  function automatic logic two_cycle(input logic [2:0] o);
    two_cycle = (o == OP_ERASE) || (o == OP_BLANK);
  endfunction

  // Permission check against the last status seen
  function automatic logic allowed(input logic [2:0] o, input logic [7:0] s,
                                   input logic rdy, input logic err);
    logic eS;
    logic pS;
    eS = s[BIT_ERASE_SUSP];
    pS = s[BIT_PROG_SUSP];
    case (o)
      OP_ERASE:  allowed = rdy && !eS && !pS && !err;
      OP_BLANK:  allowed = rdy && !eS && !pS;
      OP_SUSP:   allowed = !rdy;
      OP_RESUME: allowed = rdy && (eS || pS);
      OP_READ:   allowed = rdy && !eS && !pS;
      OP_CLEAR:  allowed = rdy;
      default:   allowed = 1'b1;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Sequencer next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic [31:0] w;
    w                 = op_words(op);
    next_state        = state;
    next_cnt          = cnt;
    next_op           = op;
    next_blockAddr    = blockAddr;
    next_flashStat    = flashStat;
    next_arrayWord    = arrayWord;
    next_refused      = refused;
    next_inStatusMode = inStatusMode;
    next_errLatch     = errLatch;
    next_pins         = pins;
    next_regRdata     = 16'h0000;
    // Register reads
    if (regRd) begin
      case (regAddr)
        REG_ADDR:   next_regRdata = blockAddr;
        REG_STATUS: next_regRdata = {10'h000, errLatch, inStatusMode, refused,
                                     rbLevel, (state != S_IDLE), 1'b0};
        REG_FSTAT:  next_regRdata = {8'h00, flashStat};
        REG_DATA:   next_regRdata = arrayWord;
        default:    next_regRdata = 16'h0000;
      endcase
    end
    // Register writes
    if (regWr && regAddr == REG_ADDR) begin
      next_blockAddr = regWdata;
    end
    case (state)
      S_IDLE: begin
        if (regWr && regAddr == REG_CTRL) begin
          if (allowed(regWdata[2:0], flashStat, rbLevel, errLatch)) begin
            next_op       = regWdata[2:0];
            next_refused  = 1'b0;
            next_cnt      = 8'(BUS_CYC);
            next_state    = S_WR1;
            w             = op_words(regWdata[2:0]);
            next_pins.chipSelectN  = 1'b0;
            next_pins.writeEnableN = 1'b0;
            next_pins.dataOe       = 1'b1;
            next_pins.dataOut      = w[31:16];
            next_pins.addr         = {blockAddr, 8'h00};
          end else begin
            next_refused = 1'b1;
          end
        end
      end
      S_WR1, S_WR2: begin
        if (cnt == 8'h00) begin
          next_pins.chipSelectN  = 1'b1;
          next_pins.writeEnableN = 1'b1;
          next_cnt               = 8'(BUS_CYC);
          if (state == S_WR1 && two_cycle(op)) begin
            next_state = S_GAP;
          end else begin
            next_pins.dataOe = 1'b0;
            next_state       = (op == OP_SUSP) ? S_DONE : S_RD;
          end
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      S_GAP: begin
        if (cnt == 8'h00) begin
          next_cnt               = 8'(BUS_CYC);
          next_pins.chipSelectN  = 1'b0;
          next_pins.writeEnableN = 1'b0;
          next_pins.dataOut      = w[15:0];
          next_state             = S_WR2;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      S_RD: begin
        // Fresh chip select and output enable edge refreshes status
        next_pins.chipSelectN = 1'b0;
        next_pins.outEnableN  = 1'b0;
        if (cnt == 8'h00) begin
          next_pins.chipSelectN = 1'b1;
          next_pins.outEnableN  = 1'b1;
          if (op == OP_READ) begin
            next_arrayWord    = dataSync;
            next_inStatusMode = 1'b0;
          end else begin
            next_flashStat    = dataSync[7:0];
            next_inStatusMode = 1'b1;
            if (dataSync[BIT_ERASE_ERR]) begin
              next_errLatch = 1'b1;
            end
          end
          if (op == OP_CLEAR) begin
            next_errLatch = 1'b0;
          end
          next_state = S_DONE;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      S_DONE: begin
        // Suspend leaves the read mode alone
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state        <= S_IDLE;
      cnt          <= 8'h00;
      op           <= 3'h0;
      blockAddr    <= RST_DATA;
      flashStat    <= 8'h80;
      arrayWord    <= RST_DATA;
      refused      <= 1'b0;
      inStatusMode <= 1'b0;
      errLatch     <= 1'b0;
      regRdata     <= RST_DATA;
      pins         <= '{chipSelectN: 1'b1, outEnableN: 1'b1, writeEnableN: 1'b1,
                        resetPinN: 1'b1, dataOe: 1'b0, addr: 24'h000000,
                        dataOut: 16'h0000};
    end else begin
      state        <= next_state;
      cnt          <= next_cnt;
      op           <= next_op;
      blockAddr    <= next_blockAddr;
      flashStat    <= next_flashStat;
      arrayWord    <= next_arrayWord;
      refused      <= next_refused;
      inStatusMode <= next_inStatusMode;
      errLatch     <= next_errLatch;
      regRdata     <= next_regRdata;
      pins         <= next_pins;
    end
  end

endmodule

/* File: rtl/febs_pkg.sv */
// Package for the flash erase, blank check and suspend host controller
package febs_pkg;

  // ----------------------------------------------------------------------
  // Command codes written on the flash data bus
  // ----------------------------------------------------------------------
  localparam logic [15:0] CMD_ERASE_SETUP  = 16'h0020;  // Erase setup
  localparam logic [15:0] CMD_CONFIRM      = 16'h00D0;  // Erase confirm / resume
  localparam logic [15:0] CMD_SUSPEND      = 16'h00B0;  // Suspend
  localparam logic [15:0] CMD_BLANK_SETUP  = 16'h00BC;  // Blank check setup
  localparam logic [15:0] CMD_BLANK_CONF   = 16'h00CB;  // Blank check confirm
  localparam logic [15:0] CMD_READ_STATUS  = 16'h0070;  // Read status mode
  localparam logic [15:0] CMD_CLEAR_STATUS = 16'h0050;  // Clear status
  localparam logic [15:0] CMD_READ_ARRAY   = 16'h00FF;  // Read array mode

  // ----------------------------------------------------------------------
  // Status register bit positions
  // ----------------------------------------------------------------------
  localparam int BIT_READY      = 7;  // Ready flag
  localparam int BIT_ERASE_SUSP = 6;  // Erase suspended flag
  localparam int BIT_ERASE_ERR  = 5;  // Erase error flag
  localparam int BIT_PROG_SUSP  = 2;  // Program suspended flag

  // ----------------------------------------------------------------------
  // Software register offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;  // Command register (write)
  localparam logic [3:0] REG_ADDR   = 4'h1;  // Block address
  localparam logic [3:0] REG_STATUS = 4'h2;  // Controller status (read)
  localparam logic [3:0] REG_FSTAT  = 4'h3;  // Last flash status byte
  localparam logic [3:0] REG_DATA   = 4'h4;  // Last array word read

  // ----------------------------------------------------------------------
  // Operation codes in the command register
  // ----------------------------------------------------------------------
  localparam logic [2:0] OP_ERASE  = 3'h1;  // Block erase
  localparam logic [2:0] OP_BLANK  = 3'h2;  // Blank check
  localparam logic [2:0] OP_SUSP   = 3'h3;  // Suspend
  localparam logic [2:0] OP_RESUME = 3'h4;  // Resume
  localparam logic [2:0] OP_CLEAR  = 3'h5;  // Clear status
  localparam logic [2:0] OP_POLL   = 3'h6;  // Read status once
  localparam logic [2:0] OP_READ   = 3'h7;  // Read array word

  // ----------------------------------------------------------------------
  // Timing and reset values
  // ----------------------------------------------------------------------
  localparam int BUS_NS       = 80;  // Strobe width in ns
  localparam int CLK_NS       = 4;   // Clock period in ns
  localparam int BUS_CYC      = (BUS_NS + CLK_NS - 1) / CLK_NS;  // Strobe timer load, one less than the strobe's low cycles
  localparam int SYNC_STAGES  = 2;   // Ready pin synchroniser depth
  localparam logic [15:0] RST_DATA = 16'h0000;  // Register reset value

  // ----------------------------------------------------------------------
  // Flash pin bundle driven by the controller
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        chipSelectN;   // Chip select, active low
    logic        outEnableN;    // Output enable, active low
    logic        writeEnableN;  // Write enable, active low
    logic        resetPinN;     // Device reset, active low
    logic        dataOe;        // Controller drives data bus
    logic [23:0] addr;          // Address bus
    logic [15:0] dataOut;       // Data to flash
  } febs_pins_t;

endpackage

/* File: verification/febs_ctrl_asserts.sv */
// Port assertions for the flash erase controller
`timescale 1ns/1ps
module febs_ctrl_asserts
  import febs_pkg::*;
(
  input wire logic             clk,          // Clock
  input wire logic             rst,          // Reset
  input wire logic [3:0]       regAddr,      // Register address
  input wire logic [15:0]      regWdata,     // Write data
  input wire logic             regWr,        // Write strobe
  input wire logic             regRd,        // Read strobe
  input wire logic [15:0]      regRdata,     // Read data
  input wire febs_pkg::febs_pins_t pins,     // Flash pins
  input wire logic [15:0]      flashDataIn,  // Flash data
  input wire logic             readyBusyIn   // Ready pin
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  localparam int STROBE = BUS_CYC + 1;  // Low cycles per strobe
  int weLow = 0;                        // Write strobe low count
  // Count cycles with the write strobe low
  always_ff @(posedge clk) weLow <= pins.writeEnableN ? 0 : weLow + 1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // One flash write cycle starting with a given code
  sequence s_wr(logic [15:0] c);
    $fell(pins.writeEnableN) && pins.dataOut == c;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_rdata_idle: assert property (!$past(regRd) |-> regRdata == 16'h0000)
    else $error("read data outside its cycle");
  chk_release_quiet: assert property ($fell(rst) |-> pins.writeEnableN && pins.outEnableN
    && pins.chipSelectN && !pins.dataOe) else $error("strobes active at reset");
  chk_reset_held: assert property (pins.resetPinN)
    else $error("device reset pin pulled");
  chk_we_width: assert property ($rose(pins.writeEnableN) |-> weLow == STROBE)
    else $error("write strobe width wrong");
  chk_write_drive: assert property (!pins.writeEnableN |-> pins.dataOe && !pins.chipSelectN)
    else $error("write without data or select");
  chk_no_clash: assert property (!pins.outEnableN |-> !pins.dataOe)
    else $error("data bus driven during read");
  chk_erase_pair: assert property (s_wr(CMD_ERASE_SETUP) |-> ##[40:44] s_wr(CMD_CONFIRM))
    else $error("erase setup without confirm");
  chk_blank_pair: assert property (s_wr(CMD_BLANK_SETUP) |-> ##[40:44] s_wr(CMD_BLANK_CONF))
    else $error("blank setup without confirm");
endmodule

bind febs_ctrl febs_ctrl_asserts febs_ctrl_asserts_i (.clk(clk), .rst(rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pins(pins),
  .flashDataIn(flashDataIn), .readyBusyIn(readyBusyIn));

/* File: verification/febs_flash_model.sv */
// Behavioural flash device for erase, blank check and suspend
`timescale 1ns/1ps
module febs_flash_model
  import febs_pkg::*;
#(
  parameter int BUSY_CYC = 400  // Internal operation length
) (
  input  wire logic                clk,       // Model clock
  input  wire febs_pkg::febs_pins_t pins,     // Controller pins
  output logic [15:0]              dataOut,   // Flash data bus
  output logic                     readyBusy  // Ready/busy level
);
  logic [15:0] wd = 16'h0000;     // Data of write in flight
  logic [15:0] lastD = 16'h0000;  // Last value driven
  logic        weQ = 1'b1;        // Previous write strobe
  logic [1:0]  pend = 2'h0;       // Pending setup, 1 erase, 2 blank
  int          left = 0;          // Cycles of work left
  logic susp = 0, err = 0, stMode = 0, clean = 0, isErase = 0;  // Device state
  logic        run;               // Working, not suspended
  assign run = left > 0 && !susp;
  assign readyBusy = !run;
  // Status on low byte, array only when idle; released bus shows inverse
  assign dataOut = (pins.chipSelectN || pins.outEnableN) ? ~lastD :
    stMode ? {8'h00, !run, susp, err, 5'h00} :
    run ? ~lastD : (clean ? 16'hFFFF : 16'h0000);
  // Command decode at the end of each write strobe
  always @(posedge clk) begin
    weQ <= pins.writeEnableN;
    if (!pins.writeEnableN) wd <= pins.dataOut;
    if (!pins.outEnableN) lastD <= dataOut;
    if (run) left <= left - 1;
    if (run && left == 1 && isErase) clean <= 1'b1;
    if (run && left == 1 && !isErase && !clean) err <= 1'b1;
    if (pins.writeEnableN && !weQ) begin
      pend <= 2'h0;
      if (run) begin
        if (wd == CMD_SUSPEND && isErase) susp <= 1'b1;
        if (wd == CMD_READ_ARRAY) stMode <= 1'b0;
      end else if (pend == 2'h1 && wd == CMD_CONFIRM && !err && !susp) begin
        left <= BUSY_CYC;
        isErase <= 1'b1;
        stMode <= 1'b1;
        clean <= 1'b0;
      end else if (pend == 2'h2 && wd == CMD_BLANK_CONF && !susp) begin
        left <= BUSY_CYC;
        isErase <= 1'b0;
        stMode <= 1'b1;
      end else begin
        case (wd)
          CMD_ERASE_SETUP:  pend <= 2'h1;
          CMD_BLANK_SETUP:  pend <= 2'h2;
          CMD_CONFIRM:      if (susp) begin susp <= 1'b0; stMode <= 1'b1; end
          CMD_CLEAR_STATUS: err <= 1'b0;
          CMD_READ_STATUS:  stMode <= 1'b1;
          CMD_READ_ARRAY:   stMode <= 1'b0;
          default:          ;
        endcase
      end
    end
  end
endmodule

/* File: verification/febs_ctrl_tb.sv */
// Self-checking bench for the flash erase and suspend controller
`timescale 1ns/1ps
module febs_ctrl_tb;
  import febs_pkg::*;
  logic        clk = 0, rst = 1, regWr = 0, regRd = 0, readyBusy;  // Bench drives; readyBusy from the flash model
  logic [3:0]  regAddr = 4'h0;                                   // Register address
  logic [15:0] regWdata = 16'h0000, regRdata, flashData, got, s;  // Data
  febs_pins_t  pins;                                             // Flash pins
  int          error_cnt = 0, n_compared = 0;                    // Counters
  always #2 clk = ~clk;
  febs_ctrl febs_ctrl_i (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pins(pins), .flashDataIn(flashData),
    .readyBusyIn(readyBusy));
  febs_flash_model febs_flash_model_i (.clk(clk), .pins(pins), .dataOut(flashData),
    .readyBusy(readyBusy));
  // Compare and count
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // One-cycle register write and read
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  // Issue an operation, wait until the controller is idle
  task automatic op(input logic [2:0] c);
    wr(REG_CTRL, {13'h0000, c});
    for (int i = 0; i < 100; i++) begin
      rd(REG_STATUS, s);
      if (s[1] === 1'b0) break;
    end
    if (s[1] !== 1'b0) begin
      error_cnt++;
      $display("BAD t=%0t busy %h exp %h", $time, s, 16'h0000);
    end
  endtask
  // Poll the device until its ready flag is set
  task automatic wait_ready();
    for (int i = 0; i < 60; i++) begin
      op(OP_POLL);
      rd(REG_FSTAT, got);
      if (got[7] === 1'b1) break;
    end
    if (got[7] !== 1'b1) begin
      error_cnt++;
      $display("BAD t=%0t ready %h exp %h", $time, got, 16'h0080);
    end
  endtask
  task automatic t_blank_fail();
    wr(REG_ADDR, 16'h0005);
    op(OP_BLANK);
    chk(s & 16'h0008, 16'h0000);
    chk(pins.addr[23:8], 16'h0005);
    rd(REG_ADDR, got);
    chk(got, 16'h0005);
    wait_ready();
    chk(got, 16'h00A0);
    op(OP_ERASE);
    chk(s & 16'h0008, 16'h0008);
    op(OP_CLEAR);
    wait_ready();
    chk(got, 16'h0080);
    $display("test blank_fail done");
  endtask
  task automatic t_erase();
    op(OP_ERASE);
    rd(REG_STATUS, s);
    chk(s & 16'h0004, 16'h0000);
    chk(s & 16'h0010, 16'h0010);
    op(OP_READ);
    chk(s & 16'h0008, 16'h0008);
    wait_ready();
    chk(got, 16'h0080);
    op(OP_READ);
    rd(REG_DATA, got);
    chk(got, 16'hFFFF);
    op(OP_BLANK);
    wait_ready();
    chk(got, 16'h0080);
    $display("test erase done");
  endtask
  task automatic t_suspend();
    op(OP_SUSP);
    chk(s & 16'h0008, 16'h0008);
    op(OP_ERASE);
    op(OP_SUSP);
    chk(s & 16'h0008, 16'h0000);
    op(OP_POLL);
    rd(REG_FSTAT, got);
    chk(got, 16'h00C0);
    op(OP_READ);
    chk(s & 16'h0008, 16'h0008);
    op(OP_BLANK);
    chk(s & 16'h0008, 16'h0008);
    op(OP_ERASE);
    chk(s & 16'h0008, 16'h0008);
    op(OP_RESUME);
    op(OP_POLL);
    rd(REG_FSTAT, got);
    chk(got, 16'h0000);
    wait_ready();
    chk(got, 16'h0080);
    $display("test suspend done");
  endtask
  // Verdict and end of run
  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_blank_fail();
    t_erase();
    t_suspend();
    end_sim();
  end
  // Watchdog
  initial begin
    #300000;
    error_cnt++;
    end_sim();
  end
endmodule
